// >>> pkg/fuse_lock_params.svh
// Purpose: named offsets, reset values, field positions and timing of the fuse/lock decoder
// Assumes: 8-bit register port, 10 MHz clock
// Notes: definitions only
`ifndef FUSE_LOCK_PARAMS_SVH
`define FUSE_LOCK_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_OSC_SLEEP_FUSES 4'h2
`define OFS_STARTUP_FUSES 4'h4
`define OFS_BROWNOUT_FUSES 4'h5
`define OFS_LOCK_LEVELS 4'h7

// ----------------------------------------
// reset values (unprogrammed state)
// ----------------------------------------
`define RST_OSC_SLEEP_FUSES 8'hff
`define RST_STARTUP_FUSES 8'hfe
`define RST_BROWNOUT_FUSES 8'hff
`define RST_LOCK_LEVELS 8'hff
`define READ_UNMAPPED 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FLD_TIMER_OSC_PIN 5
`define FLD_SLEEP_MODE 1:0
`define FLD_EXT_RESET_DIS 4
`define FLD_STARTUP_SEL 3:2
`define FLD_WDOG_LOCK 1
`define FLD_SCAN_ENABLE 0
`define FLD_BROWNOUT_RSVD 7:6
`define FLD_ACTIVE_MODE 5:4
`define FLD_EEPROM_KEEP 3
`define FLD_TRIP_LEVEL 2:0
`define FLD_BOOT_LOCK 7:6
`define FLD_BOOT_READ_OPEN 7
`define FLD_BOOT_WRITE_OPEN 6
`define BROWNOUT_RSVD_ONES 2'h3
`define LOCK_OTHER_ONES 6'h3f

// ----------------------------------------
// codes
// ----------------------------------------
`define STARTUP_SEL_LONG 2'h0
`define STARTUP_SEL_SHORT 2'h1
`define STARTUP_SEL_NONE 2'h3
`define STARTUP_TICKS_LONG 7'h40
`define STARTUP_TICKS_SHORT 7'h04
`define STARTUP_TICKS_NONE 7'h00
`define MODE_SAMPLED 2'h1
`define MODE_CONTINUOUS 2'h2
`define MODE_OFF 2'h3
`define MODE_RESERVED 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define ULP_PERIOD_NS 1000000
`define ULP_TICK_CYCLES (`ULP_PERIOD_NS / `CLK_PERIOD_NS)
`define FUSE_WRITE_TIMEOUT_NS 10000
`define FUSE_WRITE_CYCLES ((`FUSE_WRITE_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> pkg/fuse_lock_pkg.sv
// Purpose: types shared by the fuse/lock decoder and its bench
// Assumes: constants live in fuse_lock_params.svh
// Notes: none
package fuse_lock_pkg;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic enabled;
      logic sampled;
      logic reserved_code;
      logic [2:0] trip_level;
   } brownout_cfg_s;

   typedef struct packed {
      logic store_req;
      logic load_req;
      logic exec_in_boot;
      logic target_in_boot;
      logic vectors_in_app;
   } nvm_access_s;

   typedef struct packed {
      logic store_block;
      logic load_block;
      logic irq_disable;
   } lock_verdict_s;

   typedef enum logic [1:0] {ST_LOAD, ST_DELAY, ST_RUN} startup_state_e;

endpackage

// >>> rtl/fuse_lock_config_decode.sv
// Purpose: fuse and boot lock store, reset-time latch, start-up delay and lock enforcement
// Assumes: por_n_i only at power-up; reset_n_i for every system reset
// Notes: register port data is 8 bits; read data valid the cycle after rd_i
`timescale 1ns/10ps
`include "fuse_lock_params.svh"

module fuse_lock_config_decode
   import fuse_lock_pkg::*;
#(
   parameter int unsigned ULP_TICK_CYCLES = `ULP_TICK_CYCLES
) (
   // clock and resets
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic por_n_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // reset pin and reset sequencing
   input wire logic ext_reset_pin_n_i,
   output logic ext_reset_o,
   output logic internal_reset_o,
   // oscillator, brownout, scan port
   output logic timer_osc_on_xtal_o,
   input wire logic deep_sleep_i,
   output fuse_lock_pkg::brownout_cfg_s brownout_cfg_o,
   output logic boundary_scan_port_enable_o,
   // watchdog
   input wire logic wdog_cfg_wr_i,
   output logic wdog_cfg_wr_allow_o,
   output logic wdog_force_enable_o,
   // chip erase
   input wire logic chip_erase_i,
   output logic fuse_write_busy_o,
   output logic erase_flash_o,
   output logic erase_sram_o,
   output logic erase_eeprom_o,
   // self-programming and program-memory loads
   input wire fuse_lock_pkg::nvm_access_s nvm_access_i,
   output fuse_lock_pkg::lock_verdict_s lock_verdict_o
);
   import fuse_lock_pkg::*;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   // nonvolatile copies survive reset_n_i; power-up restores defaults, and chip erase restores the boot lock
   logic [7:0] osc_sleep_fuses;
   logic [7:0] startup_reset_watchdog_fuses;
   logic [7:0] brownout_eeprom_fuses;
   logic [1:0] boot_section_lock;
   // copies taken at the end of each reset; eeprom_keep_live at the end of each write timeout
   logic [7:0] osc_sleep_live;
   logic [7:0] startup_live;
   logic [7:0] brownout_live;
   logic eeprom_keep_live;
   logic [6:0] write_timer;
   logic [6:0] tick_count;
   startup_state_e state;
   logic ulp_tick;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   localparam logic [6:0] WRITE_LAST = 7'(`FUSE_WRITE_CYCLES - 1);
   localparam logic [7:0] LOCK_DEFAULT = `RST_LOCK_LEVELS;
   wire fuse_busy = (write_timer != 7'h00);
   wire wr_osc = wr_i && !fuse_busy && (addr_i == `OFS_OSC_SLEEP_FUSES);
   wire wr_startup = wr_i && !fuse_busy && (addr_i == `OFS_STARTUP_FUSES);
   wire wr_brownout = wr_i && !fuse_busy && (addr_i == `OFS_BROWNOUT_FUSES);
   wire wr_lock = wr_i && (addr_i == `OFS_LOCK_LEVELS);
   wire any_fuse_wr = wr_osc || wr_startup || wr_brownout;
   wire timeout_end = (write_timer == 7'h01);
   wire [1:0] next_boot_lock = boot_section_lock & wdata_i[`FLD_BOOT_LOCK];
   wire [7:0] lock_read = {boot_section_lock, `LOCK_OTHER_ONES};
   wire [7:0] read_mux =
      (addr_i == `OFS_OSC_SLEEP_FUSES) ? osc_sleep_fuses :
      (addr_i == `OFS_STARTUP_FUSES) ? startup_live :
      (addr_i == `OFS_BROWNOUT_FUSES) ? brownout_eeprom_fuses :
      (addr_i == `OFS_LOCK_LEVELS) ? lock_read : `READ_UNMAPPED;

   // ----------------------------------------
   // fuse and lock store
   // ----------------------------------------
   // fuse bytes are kept as written, except brownout bits 7:6 forced to ones; lock writes only clear bits; other reserved bits rely on software writing ones
   always_ff @(posedge mclk_i or negedge por_n_i)
   begin
      if (!por_n_i)
      begin
         osc_sleep_fuses <= `RST_OSC_SLEEP_FUSES;
         startup_reset_watchdog_fuses <= `RST_STARTUP_FUSES;
         brownout_eeprom_fuses <= `RST_BROWNOUT_FUSES;
         boot_section_lock <= LOCK_DEFAULT[`FLD_BOOT_LOCK];
         write_timer <= 7'h00;
         eeprom_keep_live <= 1'b1;
      end
      else
      begin
         if (wr_osc)
            osc_sleep_fuses <= wdata_i;
         if (wr_startup)
            startup_reset_watchdog_fuses <= wdata_i;
         if (wr_brownout)
            brownout_eeprom_fuses <= {`BROWNOUT_RSVD_ONES, wdata_i[5:0]};
         if (chip_erase_i)
            boot_section_lock <= LOCK_DEFAULT[`FLD_BOOT_LOCK];
         else if (wr_lock)
            boot_section_lock <= next_boot_lock;
         if (any_fuse_wr)
            write_timer <= WRITE_LAST + 7'h01;
         else if (fuse_busy)
            write_timer <= write_timer - 7'h01;
         if (timeout_end)
            eeprom_keep_live <= brownout_eeprom_fuses[`FLD_EEPROM_KEEP];
      end
   end

   // ----------------------------------------
   // reset-time latch and start-up delay
   // ----------------------------------------
   wire ext_reset_disabled = !startup_live[`FLD_EXT_RESET_DIS];
   wire ext_reset_req = !ext_reset_pin_n_i && !ext_reset_disabled;
   wire [1:0] startup_sel = startup_live[`FLD_STARTUP_SEL];
   // the reserved code falls back to the longest delay
   wire [6:0] delay_target =
      (startup_sel == `STARTUP_SEL_SHORT) ? `STARTUP_TICKS_SHORT :
      (startup_sel == `STARTUP_SEL_NONE) ? `STARTUP_TICKS_NONE : `STARTUP_TICKS_LONG;
   wire delay_done = (tick_count == delay_target);
   wire next_tick_count_en = (state == ST_DELAY) && ulp_tick;
   startup_state_e next_state;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_LOAD: next_state = ST_DELAY;
         ST_DELAY: next_state = delay_done ? ST_RUN : ST_DELAY;
         ST_RUN: next_state = ST_RUN;
      endcase
      if (ext_reset_req)
         next_state = ST_LOAD;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= ST_LOAD;
         tick_count <= 7'h00;
         startup_live <= `RST_STARTUP_FUSES;
         osc_sleep_live <= `RST_OSC_SLEEP_FUSES;
         brownout_live <= `RST_BROWNOUT_FUSES;
      end
      else
      begin
         state <= next_state;
         if (state == ST_LOAD)
         begin
            startup_live <= startup_reset_watchdog_fuses;
            osc_sleep_live <= osc_sleep_fuses;
            brownout_live <= brownout_eeprom_fuses;
            tick_count <= 7'h00;
         end
         else if (next_tick_count_en && !delay_done)
            tick_count <= tick_count + 7'h01;
      end
   end

   ulp_tick_divider #(
      .TICK_CYCLES(ULP_TICK_CYCLES)
   ) u_ulp_tick (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .restart_i(state == ST_LOAD),
      .tick_o(ulp_tick)
   );

   // ----------------------------------------
   // decoded settings
   // ----------------------------------------
   wire [1:0] mode_code =
      deep_sleep_i ? osc_sleep_live[`FLD_SLEEP_MODE] : brownout_live[`FLD_ACTIVE_MODE];
   wire wdog_locked = !startup_live[`FLD_WDOG_LOCK];

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdata_o <= `READ_UNMAPPED;
         brownout_cfg_o <= '0;
         timer_osc_on_xtal_o <= 1'b1;
         erase_flash_o <= 1'b0;
         erase_sram_o <= 1'b0;
         erase_eeprom_o <= 1'b0;
      end
      else
      begin
         rdata_o <= rd_i ? read_mux : `READ_UNMAPPED;
         timer_osc_on_xtal_o <= osc_sleep_live[`FLD_TIMER_OSC_PIN];
         brownout_cfg_o.enabled <= (mode_code == `MODE_SAMPLED) ||
            (mode_code == `MODE_CONTINUOUS);
         brownout_cfg_o.sampled <= (mode_code == `MODE_SAMPLED);
         brownout_cfg_o.reserved_code <= (mode_code == `MODE_RESERVED);
         brownout_cfg_o.trip_level <= brownout_live[`FLD_TRIP_LEVEL];
         erase_flash_o <= chip_erase_i;
         erase_sram_o <= chip_erase_i;
         erase_eeprom_o <= chip_erase_i && eeprom_keep_live;
      end
   end

   assign ext_reset_o = ext_reset_req;
   assign internal_reset_o = (state != ST_RUN);
   assign boundary_scan_port_enable_o = !startup_live[`FLD_SCAN_ENABLE];
   // window enable is left to software even when locked
   assign wdog_cfg_wr_allow_o = wdog_cfg_wr_i && !wdog_locked;
   assign wdog_force_enable_o = wdog_locked;
   assign fuse_write_busy_o = fuse_busy;

   // ----------------------------------------
   // boot section lock enforcement
   // ----------------------------------------
   wire boot_write_locked = !boot_section_lock[1'b0];
   wire boot_read_locked = !boot_section_lock[1'b1];
   assign lock_verdict_o.store_block = nvm_access_i.store_req &&
      nvm_access_i.target_in_boot && boot_write_locked;
   assign lock_verdict_o.load_block = nvm_access_i.load_req && !nvm_access_i.exec_in_boot &&
      nvm_access_i.target_in_boot && boot_read_locked;
   assign lock_verdict_o.irq_disable = boot_read_locked && nvm_access_i.vectors_in_app &&
      nvm_access_i.exec_in_boot;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   ext_reset_restart_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (!ext_reset_pin_n_i && startup_live[`FLD_EXT_RESET_DIS]) |=> state == ST_LOAD)
      else $error("reset pin low did not restart the sequence");

   ext_reset_ignored_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (!startup_live[`FLD_EXT_RESET_DIS] && state == ST_RUN) |=> state == ST_RUN)
      else $error("disabled reset pin still reset the device");

   startup_release_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(!internal_reset_o) |-> tick_count == delay_target && $past(state) == ST_DELAY)
      else $error("internal reset released before the delay count");

   zero_delay_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (state == ST_DELAY && startup_sel == `STARTUP_SEL_NONE && ext_reset_pin_n_i)
      |=> state == ST_RUN)
      else $error("zero start-up delay was not immediate");

   latched_read_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `OFS_STARTUP_FUSES) |=> rdata_o == $past(startup_live))
      else $error("startup fuse read did not return the latched copy");

   lock_tighten_a:
   assert property (@(posedge mclk_i) disable iff (!por_n_i)
      (wr_lock && !chip_erase_i) |=>
      boot_section_lock == ($past(boot_section_lock) & $past(wdata_i[7:6])))
      else $error("boot lock loosened by a write");

   eeprom_commit_a:
   assert property (@(posedge mclk_i) disable iff (!por_n_i)
      $fell(fuse_busy) |-> eeprom_keep_live == brownout_eeprom_fuses[`FLD_EEPROM_KEEP])
      else $error("keep fuse not effective after the write timeout");

   eeprom_erase_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      chip_erase_i |=> erase_flash_o && (erase_eeprom_o == $past(eeprom_keep_live)))
      else $error("chip erase outputs wrong");

   wdog_reject_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (wdog_cfg_wr_i && !startup_live[`FLD_WDOG_LOCK]) |-> !wdog_cfg_wr_allow_o &&
      wdog_force_enable_o)
      else $error("locked watchdog accepted a change");

   boot_store_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (nvm_access_i.store_req && nvm_access_i.target_in_boot) |->
      lock_verdict_o.store_block == (boot_section_lock == 2'h2 || boot_section_lock == 2'h0))
      else $error("boot store verdict wrong");

   boot_load_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (nvm_access_i.load_req && !nvm_access_i.exec_in_boot && nvm_access_i.target_in_boot &&
      boot_section_lock == 2'h0) |-> lock_verdict_o.load_block)
      else $error("read-locked boot section was loaded");

   brownout_mode_a:
   assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (deep_sleep_i && osc_sleep_live[1:0] == `MODE_OFF) |=> !brownout_cfg_o.enabled)
      else $error("brownout enabled in sleep despite off code");
endmodule

// >>> rtl/ulp_tick_divider.sv
// Purpose: one-cycle enable at the low-power oscillator rate, divided from mclk_i
// Assumes: TICK_CYCLES >= 2
// Notes: restart_i realigns the phase so a delay starts on a whole period
`timescale 1ns/10ps
module ulp_tick_divider #(
   parameter int unsigned TICK_CYCLES = 10000
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // control
   input wire logic restart_i,
   // enable out
   output logic tick_o
);
   localparam int unsigned CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] count;
   wire at_last = (count == LAST);

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         count <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         count <= (restart_i || at_last) ? '0 : count + 1'b1;
         tick_o <= at_last && !restart_i;
      end
   end
endmodule

// >>> tb/fuse_programmer_model.sv
// Purpose: programmer and software side of the fuse/lock register port
// Assumes: strobes change by non-blocking assignment just after a rising edge
// Notes: reserved fuse bits are always written as one
`timescale 1ns/10ps
module fuse_programmer_model (
   // clock
   input wire logic mclk_i,
   // register port
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   logic wdog_window_en;

   initial
   begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdog_window_en = 1'b0;
   end

   // reserved bits of each fuse byte; lock byte has none here
   function automatic logic [7:0] rsvd(input logic [3:0] a);
      case (a)
         4'h2: rsvd = 8'h9c;
         4'h4: rsvd = 8'he0;
         4'h5: rsvd = 8'hc0;
         default: rsvd = 8'h00;
      endcase
   endfunction

   task automatic write(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d | rsvd(a);
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe, so both cycles are sampled
   task automatic read(input logic [3:0] a, output logic [7:0] d, output logic [7:0] late);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
      @(posedge mclk_i);
      #1 late = rdata_i;
   endtask

   // the device never sets window mode by itself, even when locked
   task automatic set_window();
      wdog_window_en = 1'b1;
   endtask
endmodule

// >>> tb/test_fuse_lock_config_decode.sv
// Purpose: self-checking bench of the fuse/lock decoder
// Assumes: tick divider shortened to 8 cycles
// Notes: delay figures allow one cycle of slack either way
`timescale 1ns/10ps
module test_fuse_lock_config_decode;
   import fuse_lock_pkg::*;
   localparam int T = 8;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic por_n_i = 1'b0;
   logic [3:0] addr_i;
   logic [7:0] wdata_i;
   logic [7:0] rdata_o;
   logic wr_i;
   logic rd_i;
   logic ext_reset_pin_n_i = 1'b1;
   logic ext_reset_o;
   logic internal_reset_o;
   logic timer_osc_on_xtal_o;
   logic deep_sleep_i = 1'b0;
   brownout_cfg_s brownout_cfg_o;
   logic boundary_scan_port_enable_o;
   logic wdog_cfg_wr_i = 1'b0;
   logic wdog_cfg_wr_allow_o;
   logic wdog_force_enable_o;
   logic chip_erase_i = 1'b0;
   logic fuse_write_busy_o;
   logic erase_flash_o;
   logic erase_sram_o;
   logic erase_eeprom_o;
   nvm_access_s nvm_access_i = '0;
   lock_verdict_s lock_verdict_o;
   int n_errors = 0;
   int cmp_count = 0;
   logic [3:0] ra [5] = '{4'h2, 4'h4, 4'h5, 4'h7, 4'h3};
   logic [7:0] rv [5] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'h00};
   logic [7:0] f4v [5] = '{8'hfe, 8'hed, 8'hf7, 8'hf3, 8'hfb};
   int f4n [5] = '{0, 0, 4, 64, 64};
   logic [7:0] lw [7] = '{8'hff, 8'h80, 8'hc0, 8'h40, 8'hff, 8'h00, 8'h7f};
   logic [1:0] le [7] = '{2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h1};

   always #50 mclk_i = ~mclk_i;

   fuse_lock_config_decode #(.ULP_TICK_CYCLES(T)) fuse_lock_config_decode_i (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .ext_reset_pin_n_i(ext_reset_pin_n_i), .ext_reset_o(ext_reset_o),
      .internal_reset_o(internal_reset_o), .timer_osc_on_xtal_o(timer_osc_on_xtal_o),
      .deep_sleep_i(deep_sleep_i), .brownout_cfg_o(brownout_cfg_o),
      .boundary_scan_port_enable_o(boundary_scan_port_enable_o),
      .wdog_cfg_wr_i(wdog_cfg_wr_i), .wdog_cfg_wr_allow_o(wdog_cfg_wr_allow_o),
      .wdog_force_enable_o(wdog_force_enable_o), .chip_erase_i(chip_erase_i),
      .fuse_write_busy_o(fuse_write_busy_o), .erase_flash_o(erase_flash_o),
      .erase_sram_o(erase_sram_o), .erase_eeprom_o(erase_eeprom_o),
      .nvm_access_i(nvm_access_i), .lock_verdict_o(lock_verdict_o));

   fuse_programmer_model fuse_programmer_model_i (.mclk_i(mclk_i), .addr_o(addr_i),
      .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout(input string what);
      n_errors++;
      $display("BAD %s expected done seen timeout", what);
      end_of_test();
   endtask

   function automatic logic [5:0] bo_exp(input logic [1:0] c, input logic [2:0] t);
      return {c == 2'h1 || c == 2'h2, c == 2'h1, c == 2'h0, t};
   endfunction

   function automatic logic [2:0] lk_exp(input logic [1:0] lk, input nvm_access_s a);
      return {a.store_req & a.target_in_boot & ~lk[0],
         a.load_req & ~a.exec_in_boot & a.target_in_boot & ~lk[1],
         a.vectors_in_app & a.exec_in_boot & ~lk[1]};
   endfunction

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic [7:0] late;
      fuse_programmer_model_i.read(a, d, late);
      check(what, d, e);
      check({what, " later"}, late, 8'h00);
   endtask

   // drop makes a second write land inside the write timeout
   task automatic wfuse(input logic [3:0] a, input logic [7:0] d, input bit drop);
      int n;
      n = 0;
      fuse_programmer_model_i.write(a, d);
      if (drop)
         fuse_programmer_model_i.write(a, ~d);
      #1;
      while (fuse_write_busy_o !== 1'b0)
      begin
         @(posedge mclk_i);
         #1 n++;
         if (n > 300)
            timeout("busy");
      end
      if (a != 4'h7 && !drop)
         check("busy cycles", 8'(n >= 99 && n <= 101), 8'h01);
   endtask

   task automatic sys_reset(input int ticks);
      int n;
      @(posedge mclk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_i);
         #1 n++;
      end
      while (internal_reset_o !== 1'b0 && n < 2000);
      if (n >= 2000)
         timeout("start delay");
      check("start delay", 8'(n >= ticks * T + 1 && n <= ticks * T + 3), 8'h01);
   endtask

   task automatic erase(input logic keep);
      @(posedge mclk_i);
      chip_erase_i <= 1'b1;
      @(posedge mclk_i);
      chip_erase_i <= 1'b0;
      #1 check("erase", 8'({erase_flash_o, erase_sram_o, erase_eeprom_o}), 8'({2'h3, keep}));
      @(posedge mclk_i);
      #1 check("erase end", 8'({erase_flash_o, erase_sram_o, erase_eeprom_o}), 8'h00);
   endtask

   initial
   begin
      repeat (100000) @(posedge mclk_i);
      timeout("run");
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] f2;
      logic [7:0] f5;
      logic [7:0] prev;
      logic [2:0] t;
      logic [31:0] r;
      void'($urandom(29436));
      repeat (8) @(posedge mclk_i);
      por_n_i <= 1'b1;
      sys_reset(0);
      fuse_programmer_model_i.set_window();
      foreach (ra[k])
         rd_chk("reset value", ra[k], rv[k]);
      check("slow_timer_oscillator shared", 8'(timer_osc_on_xtal_o), 8'h01);
      $display("test reset values done");
      for (int i = 0; i < 4; i++)
      begin
         r = $urandom;
         t = r[2:0];
         f2 = {1'b1, r[3], i[1], 3'h7, 2'(i)};
         f5 = {2'h3, 2'(3 - i), i[0], t};
         wfuse(4'h2, f2, 1'b0);
         wfuse(4'h5, f5, 1'b1);
         rd_chk("fuse5", 4'h5, f5);
         erase(f5[3]);
         sys_reset(0);
         rd_chk("fuse2", 4'h2, f2);
         check("slow_timer_oscillator", 8'(timer_osc_on_xtal_o), 8'(i[1]));
         @(posedge mclk_i);
         deep_sleep_i <= 1'b1;
         repeat (2) @(posedge mclk_i);
         #1 check("sleep mode", 8'(brownout_cfg_o), 8'(bo_exp(2'(i), t)));
         @(posedge mclk_i);
         deep_sleep_i <= 1'b0;
         repeat (2) @(posedge mclk_i);
         #1 check("active mode", 8'(brownout_cfg_o), 8'(bo_exp(2'(3 - i), t)));
         check("trip level", 8'(brownout_cfg_o.trip_level), 8'(t));
      end
      $display("test brownout and erase done");
      prev = 8'hfe;
      foreach (f4v[k])
      begin
         wfuse(4'h4, f4v[k], 1'b0);
         rd_chk("fuse4 old", 4'h4, prev);
         sys_reset(f4n[k]);
         rd_chk("fuse4 new", 4'h4, f4v[k]);
         @(posedge mclk_i);
         ext_reset_pin_n_i <= 1'b0;
         wdog_cfg_wr_i <= 1'b1;
         #1 check("ext reset", 8'(ext_reset_o), 8'(f4v[k][4]));
         check("wdog allow", 8'(wdog_cfg_wr_allow_o), 8'(f4v[k][1]));
         check("wdog force", 8'(wdog_force_enable_o), 8'(!f4v[k][1]));
         check("scan port", 8'(boundary_scan_port_enable_o), 8'(!f4v[k][0]));
         @(posedge mclk_i);
         ext_reset_pin_n_i <= 1'b1;
         wdog_cfg_wr_i <= 1'b0;
         @(posedge mclk_i);
         #1 check("pin restart", 8'(internal_reset_o), 8'(f4v[k][4]));
         for (int w = 0; internal_reset_o !== 1'b0; w++)
         begin
            @(posedge mclk_i);
            #1;
            if (w > 2000)
               timeout("restart");
         end
         prev = f4v[k];
      end
      $display("test start-up fuses done");
      foreach (lw[k])
      begin
         if (lw[k] == 8'h00)
            erase(1'b1);
         else
            wfuse(4'h7, lw[k], 1'b0);
         rd_chk("lock", 4'h7, {le[k], 6'h3f});
         for (int j = 0; j < 8; j++)
         begin
            r = (j == 0) ? 32'h1a : (j == 1) ? 32'h05 : $urandom;
            @(posedge mclk_i);
            nvm_access_i <= r[4:0];
            #1 check("verdict", 8'(lock_verdict_o), 8'(lk_exp(le[k], r[4:0])));
         end
      end
      $display("test boot lock done");
      end_of_test();
   end
endmodule
